// *** rtl/ssp_core.sv ***
// Synchronous serial port master: clocking, framing, FIFOs, DMA, events
module ssp_core
  import ssp_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire ssp_cfg_t          cfg_i,
  input  wire logic              tx_wr_i,
  input  wire logic [DATA_W-1:0] tx_wdata_i,
  output logic                   tx_space_o,
  output logic                   rx_valid_o,
  output logic      [DATA_W-1:0] rx_rdata_o,
  input  wire logic              rx_rd_i,
  input  wire logic [IRQ_N-1:0]  int_clear_i,
  output logic      [IRQ_N-1:0]  raw_interrupt_status_o,
  output logic      [IRQ_N-1:0]  masked_interrupt_status_o,
  output logic                   irq_o,
  output ssp_dma_t               dma_req_o,
  output logic                   busy_o,
  output logic                   serial_clock_pin_o,
  output logic                   frame_select_pin_o,
  output logic                   serial_out_pin_o,
  output logic                   serial_out_pin_oe_o,
  input  wire logic              serial_in_pin_i
);

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_XFER,
    SSP_TRAIL
  } ssp_state_t;

  ssp_state_t        state_q;
  logic [6:0]        presc_q;
  logic [7:0]        rate_q;
  logic              tick_q;
  logic [6:0]        half_m1;
  logic [5:0]        edge_q;
  logic [5:0]        edge_nx;
  logic [5:0]        edge_total;
  logic              cap_now;
  logic              shf_now;
  logic              trail_q;
  logic [DATA_W-1:0] tx_sh_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic [DATA_W-1:0] rx_word;
  logic              rx_bit;
  logic              word_end;
  logic              start;
  logic              reload;
  logic              is_spi;
  logic              is_pulse;
  logic              is_cmd;
  logic [6:0]        to_q;
  logic [IRQ_N-1:0]  sticky_q;
  logic [IRQ_N-1:0]  raw;

  logic [DATA_W-1:0] txf_data;
  logic [CNT_W-1:0]  txf_cnt;
  logic              txf_empty;
  logic              txf_avail;
  logic              txf_pop;
  logic [DATA_W-1:0] rxf_data;
  logic [CNT_W-1:0]  rxf_cnt;
  logic              rxf_empty;
  logic              rxf_avail;
  logic              rxf_push;
  logic              buf_ready;

  // Left-align a word so its MSB sits in bit 15
  function automatic logic [DATA_W-1:0] ssp_align(
    input logic [DATA_W-1:0] word,
    input logic [3:0]        size_m1,
    input logic              cmd
  );
    logic [3:0] sh;
    sh = cmd ? 4'(DATA_W - CMD_BITS) : (4'hF - size_m1);
    return word << sh;
  endfunction : ssp_align

  assign is_spi   = (cfg_i.format == SSP_FMT_SPI);
  assign is_pulse = (cfg_i.format == SSP_FMT_PULSE);
  assign is_cmd   = (cfg_i.format == SSP_FMT_CMD);

  // Transmit FIFO fed by CPU writes
  ssp_fifo u_tx_fifo (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .push_i    (tx_wr_i),
    .data_i    (tx_wdata_i),
    .pop_i     (txf_pop),
    .data_o    (txf_data),
    .cnt_o     (txf_cnt),
    .empty_o   (txf_empty),
    .avail_o   (txf_avail)
  );

  // Receive FIFO fed by the shifter
  ssp_fifo u_rx_fifo (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .push_i    (rxf_push),
    .data_i    (rx_word),
    .pop_i     (!rxf_empty && buf_ready),
    .data_o    (rxf_data),
    .cnt_o     (rxf_cnt),
    .empty_o   (rxf_empty),
    .avail_o   (rxf_avail)
  );

  // Output buffer so a stalled reader loses no word
  ssp_skid u_rx_buf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (!rxf_empty),
    .in_data_i   (rxf_data),
    .in_ready_o  (buf_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_rdata_o),
    .out_ready_i (rx_rd_i)
  );

  assign tx_space_o = txf_avail;

  // Half prescale, forced even and at least two
  assign half_m1 = (cfg_i.clock_prescale_divisor < PRESC_MIN) ? 7'h00 :
                   (cfg_i.clock_prescale_divisor[7:1] - 7'h01);

  // Half-bit tick: prescale stage then rate stage
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_q <= 7'h00;
      rate_q  <= 8'h00;
      tick_q  <= 1'b0;
    end else if (!cfg_i.enable) begin
      presc_q <= 7'h00;
      rate_q  <= 8'h00;
      tick_q  <= 1'b0;
    end else if (presc_q >= half_m1) begin
      presc_q <= 7'h00;
      if (rate_q >= cfg_i.serial_clock_rate) begin
        rate_q <= 8'h00;
        tick_q <= 1'b1;
      end else begin
        rate_q <= rate_q + 8'h01;
        tick_q <= 1'b0;
      end
    end else begin
      presc_q <= presc_q + 7'h01;
      tick_q  <= 1'b0;
    end
  end

  // Edge plan per format: frame length, capture and shift edges
  always_comb begin
    edge_nx    = edge_q + 6'h01;
    edge_total = {1'b0, cfg_i.size_m1, 1'b0} + 6'h02;
    cap_now    = 1'b0;
    shf_now    = 1'b0;
    case (cfg_i.format)
      SSP_FMT_SPI: begin
        if (!cfg_i.clock_phase_bit) begin
          cap_now = edge_nx[0];
          shf_now = !edge_nx[0] && (edge_nx != edge_total);
        end else begin
          cap_now = !edge_nx[0];
          shf_now = edge_nx[0] && (edge_nx != 6'h01);
        end
      end
      SSP_FMT_PULSE: begin
        edge_total = edge_total + 6'h02;
        cap_now    = !edge_nx[0] && (edge_nx >= 6'h04);
        shf_now    = edge_nx[0] && (edge_nx >= 6'h05);
      end
      SSP_FMT_CMD: begin
        edge_total = edge_total + 6'(2 * CMD_BITS + 2);
        shf_now    = !edge_nx[0] && (edge_nx < 6'(2 * CMD_BITS));
        cap_now    = edge_nx[0] && (edge_nx >= 6'(2 * CMD_BITS + 3));
      end
      default: begin
        cap_now = 1'b0;
        shf_now = 1'b0;
      end
    endcase
  end

  // Receive bit source with loopback, word completion and FIFO handoff
  assign rx_bit   = cfg_i.loopback ? tx_sh_q[DATA_W-1] :
                    serial_in_pin_i;
  assign rx_word  = cap_now ? {rx_sh_q[DATA_W-2:0], rx_bit} : rx_sh_q;
  assign word_end = (state_q == SSP_XFER) && tick_q &&
                    (edge_nx == edge_total);
  assign rxf_push = word_end;
  assign start    = (state_q == SSP_IDLE) && tick_q && !txf_empty &&
                    cfg_i.enable;
  assign reload   = word_end && is_spi && cfg_i.clock_phase_bit &&
                    !txf_empty;
  assign txf_pop  = start || reload;

  // Frame sequencer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= SSP_IDLE;
      edge_q  <= 6'h00;
      trail_q <= 1'b0;
    end else if (!cfg_i.enable) begin
      state_q <= SSP_IDLE;
      edge_q  <= 6'h00;
      trail_q <= 1'b0;
    end else begin
      case (state_q)
        SSP_IDLE: begin
          edge_q <= 6'h00;
          if (start) begin
            state_q <= SSP_XFER;
          end
        end
        SSP_XFER: begin
          if (tick_q) begin
            edge_q <= edge_nx;
            if (word_end) begin
              edge_q <= 6'h00;
              if (reload) begin
                state_q <= SSP_XFER;
              end else if (is_pulse) begin
                state_q <= SSP_IDLE;
              end else begin
                state_q <= SSP_TRAIL;
              end
            end
          end
        end
        SSP_TRAIL: begin
          if (tick_q) begin
            trail_q <= !trail_q;
            if (trail_q) begin
              state_q <= SSP_IDLE;
            end
          end
        end
        default: begin
          state_q <= SSP_IDLE;
        end
      endcase
    end
  end

  // Transmit and receive shifters
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_sh_q <= DATA_RST;
      rx_sh_q <= DATA_RST;
    end else if (txf_pop) begin
      tx_sh_q <= ssp_align(txf_data, cfg_i.size_m1, is_cmd);
      rx_sh_q <= DATA_RST;
    end else if (word_end) begin
      tx_sh_q <= DATA_RST;                          // Idle data forced low
    end else if ((state_q == SSP_XFER) && tick_q) begin
      if (shf_now) begin
        tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
      end
      if (cap_now) begin
        rx_sh_q <= rx_word;
      end
    end
  end

  // Serial clock, frame select and data enable pins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_clock_pin_o  <= 1'b0;
      frame_select_pin_o  <= 1'b1;
      serial_out_pin_oe_o <= 1'b0;
    end else begin
      serial_out_pin_oe_o <= cfg_i.enable &&
                             (!is_pulse || state_q != SSP_IDLE);
      if (state_q == SSP_XFER && tick_q) begin
        serial_clock_pin_o <= !serial_clock_pin_o;
      end else if (state_q != SSP_XFER) begin
        serial_clock_pin_o <= is_spi && cfg_i.clock_polarity_bit;
      end
      if (is_pulse) begin
        if (start) begin
          frame_select_pin_o <= 1'b1;
        end else if (state_q == SSP_XFER && tick_q && edge_nx == 6'h02) begin
          frame_select_pin_o <= 1'b0;
        end else if (state_q != SSP_XFER) begin
          frame_select_pin_o <= 1'b0;
        end
      end else if (start) begin
        frame_select_pin_o <= 1'b0;
      end else if (state_q == SSP_IDLE ||
                   (state_q == SSP_TRAIL && tick_q && trail_q)) begin
        frame_select_pin_o <= 1'b1;
      end
    end
  end

  assign serial_out_pin_o = tx_sh_q[DATA_W-1];

  // Idle timeout counter while the receive FIFO holds data
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      to_q <= 7'h00;
    end else if (rxf_empty || state_q != SSP_IDLE) begin
      to_q <= 7'h00;
    end else if (tick_q && to_q != RX_TO_TICKS) begin
      to_q <= to_q + 7'h01;
    end
  end

  // Sticky event flags; a new event wins over a clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sticky_q <= IRQ_RST;
    end else begin
      sticky_q <= sticky_q & ~int_clear_i;
      if (tick_q && to_q == RX_TO_TICKS - 7'h01 && !rxf_empty &&
          state_q == SSP_IDLE) begin
        sticky_q[IRQ_RXTO] <= 1'b1;
      end
      if (rxf_push && !rxf_avail) begin
        sticky_q[IRQ_RXOVR] <= 1'b1;                 // Word dropped
      end
    end
  end

  // Raw sources: three live levels plus the two sticky event flags
  always_comb begin
    raw            = sticky_q;
    raw[IRQ_TXSVC] = (txf_cnt <= CNT_W'(SVC_LEVEL));
    raw[IRQ_RXSVC] = (rxf_cnt >= CNT_W'(SVC_LEVEL));
    raw[IRQ_EOT]   = txf_empty && (state_q == SSP_IDLE);
    raw[IRQ_RXTO]  = sticky_q[IRQ_RXTO];
    raw[IRQ_RXOVR] = sticky_q[IRQ_RXOVR];
  end

  // Status, interrupt and DMA outputs
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_interrupt_status_o    <= IRQ_RST;
      masked_interrupt_status_o <= IRQ_RST;
      irq_o                     <= 1'b0;
      dma_req_o                 <= '0;
      busy_o                    <= 1'b0;
    end else begin
      raw_interrupt_status_o    <= raw;
      masked_interrupt_status_o <= raw & cfg_i.interrupt_mask_reg;
      irq_o     <= |(raw & cfg_i.interrupt_mask_reg);
      busy_o    <= (state_q != SSP_IDLE) || !txf_empty;
      dma_req_o.rx_single <= cfg_i.dma_rx_en &&
                             (!rxf_empty || rx_valid_o);
      dma_req_o.rx_burst  <= cfg_i.dma_rx_en &&
                             (rxf_cnt >= CNT_W'(DMA_BURST));
      dma_req_o.tx_single <= cfg_i.dma_tx_en && txf_avail;
      dma_req_o.tx_burst  <= cfg_i.dma_tx_en &&
                             (txf_cnt <= CNT_W'(DMA_BURST));
    end
  end

endmodule : ssp_core

// *** include/ssp_pkg.sv ***
// Shared constants and types for the synchronous serial port
package ssp_pkg;

  // Data path geometry
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned DMA_BURST   = 4;
  localparam int unsigned SVC_LEVEL   = 4;

  // Frame geometry
  localparam int unsigned CMD_BITS    = 8;
  localparam logic [3:0]  SIZE_MIN_M1 = 4'h3;
  localparam logic [7:0]  PRESC_MIN   = 8'h02;

  // Receive timeout in serial bit periods, counted in half-bit ticks
  localparam int unsigned RX_TO_BITS  = 32;
  localparam logic [6:0]  RX_TO_TICKS = 7'(2 * RX_TO_BITS);

  // Interrupt source positions
  localparam int unsigned IRQ_N       = 5;
  localparam int unsigned IRQ_TXSVC   = 0;
  localparam int unsigned IRQ_RXSVC   = 1;
  localparam int unsigned IRQ_RXTO    = 2;
  localparam int unsigned IRQ_RXOVR   = 3;
  localparam int unsigned IRQ_EOT     = 4;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [IRQ_N-1:0]  IRQ_RST  = 5'h00;

  // Frame formats
  typedef enum logic [1:0] {
    SSP_FMT_SPI   = 2'h0,
    SSP_FMT_PULSE = 2'h1,
    SSP_FMT_CMD   = 2'h2
  } ssp_fmt_t;

  // Configuration carried in from the control side
  typedef struct packed {
    logic             enable;
    ssp_fmt_t         format;
    logic             clock_polarity_bit;
    logic             clock_phase_bit;
    logic             loopback;
    logic [3:0]       size_m1;
    logic [7:0]       clock_prescale_divisor;
    logic [7:0]       serial_clock_rate;
    logic             dma_rx_en;
    logic             dma_tx_en;
    logic [IRQ_N-1:0] interrupt_mask_reg;
  } ssp_cfg_t;

  // DMA request group
  typedef struct packed {
    logic rx_single;
    logic rx_burst;
    logic tx_single;
    logic tx_burst;
  } ssp_dma_t;

endpackage : ssp_pkg

// *** rtl/ssp_fifo.sv ***
// Eight-entry sixteen-bit FIFO with registered level flags
module ssp_fifo
  import ssp_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              push_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              pop_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [CNT_W-1:0]  cnt_o,
  output logic                   empty_o,
  output logic                   avail_o
);

  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [2:0]        wr_q;
  logic [2:0]        rd_q;
  logic              do_push;
  logic              do_pop;
  logic [CNT_W-1:0]  cnt_d;

  // Accept only what fits, drain only what is held
  assign do_push = push_i && (cnt_o != CNT_W'(FIFO_DEPTH));
  assign do_pop  = pop_i && (cnt_o != '0);
  assign cnt_d   = cnt_o + CNT_W'(do_push) - CNT_W'(do_pop);
  assign data_o  = mem_q[rd_q];

  // Storage array
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem_q[wr_q] <= data_i;
    end
  end

  // Pointers, count and flags
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_o   <= '0;
      empty_o <= 1'b1;
      avail_o <= 1'b1;
    end else begin
      wr_q    <= wr_q + 3'(do_push);
      rd_q    <= rd_q + 3'(do_pop);
      cnt_o   <= cnt_d;
      empty_o <= (cnt_d == '0);
      avail_o <= (cnt_d != CNT_W'(FIFO_DEPTH));
    end
  end

endmodule : ssp_fifo

// *** rtl/ssp_skid.sv ***
// Two-entry buffer with valid and ready on both sides
module ssp_skid
  import ssp_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              in_valid_i,
  input  wire logic [DATA_W-1:0] in_data_i,
  output logic                   in_ready_o,
  output logic                   out_valid_o,
  output logic      [DATA_W-1:0] out_data_o,
  input  wire logic              out_ready_i
);

  logic [DATA_W-1:0] spare_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              acc_in;
  logic              acc_out;

  assign acc_in  = in_valid_i && in_ready_o;
  assign acc_out = out_valid_o && out_ready_i;
  assign cnt_d   = cnt_q + 2'(acc_in) - 2'(acc_out);

  // Head and spare word
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_data_o <= DATA_RST;
      spare_q    <= DATA_RST;
    end else begin
      if (acc_out) begin
        out_data_o <= (cnt_q == 2'h2) ? spare_q : in_data_i;
      end else if (cnt_q == 2'h0) begin
        out_data_o <= in_data_i;
      end
      if (acc_in && (cnt_q == 2'h1) && !acc_out) begin
        spare_q <= in_data_i;
      end
    end
  end

  // Occupancy and handshake flags
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q       <= 2'h0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
    end else begin
      cnt_q       <= cnt_d;
      out_valid_o <= (cnt_d != 2'h0);
      in_ready_o  <= (cnt_d != 2'h2);
    end
  end

endmodule : ssp_skid

// *** test/ssp_assertions.sv ***
// Concurrent checks on the serial port pins, DMA and event outputs
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic             clk_sys_i,
  input wire logic             rstn_i,
  input wire ssp_cfg_t         cfg_i,
  input wire logic             tx_space_o,
  input wire logic             rx_valid_o,
  input wire logic [IRQ_N-1:0] raw_interrupt_status_o,
  input wire logic [IRQ_N-1:0] masked_interrupt_status_o,
  input wire logic             irq_o,
  input wire ssp_dma_t         dma_req_o,
  input wire logic             busy_o,
  input wire logic             serial_clock_pin_o,
  input wire logic             frame_select_pin_o,
  input wire logic             serial_out_pin_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  ssp_cfg_t         cfg_q;
  logic [IRQ_N-1:0] raw_q;
  logic [1:0]       st_q;
  wire              spi = cfg_i.format == SSP_FMT_SPI;
  wire              pls = cfg_i.format == SSP_FMT_PULSE;
  wire              sck = serial_clock_pin_o;
  wire              fss = frame_select_pin_o;
  wire [IRQ_N-1:0]  raw = raw_interrupt_status_o;
  // Configuration and sources unchanged since the previous edge
  wire              calm = (cfg_q == cfg_i) && (raw_q == raw);
  // Counts cycles with unchanged configuration and event sources
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= '0;
      raw_q <= IRQ_RST;
      st_q  <= 2'h0;
    end else begin
      cfg_q <= cfg_i;
      raw_q <= raw;
      if (cfg_q != cfg_i || raw_q != raw) st_q <= 2'h0;
      else if (st_q != 2'h3) st_q <= st_q + 2'h1;
    end
  end
  sequence s_pulse_hi;
    fss [*2] ##1 !fss;
  endsequence
  property p_clk_idle;
    spi && st_q[1] && calm && fss |-> sck == cfg_i.clock_polarity_bit;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock off idle level");
  property p_frame_hold;
    !pls && $fell(fss) |-> !fss [*8];
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame released early");
  property p_pulse_hi;
    pls && cfg_i.clock_prescale_divisor == PRESC_MIN &&
      cfg_i.serial_clock_rate == 8'h00 && $rose(fss) |-> s_pulse_hi;
  endproperty
  a_pulse_hi: assert property (p_pulse_hi)
    else $error("frame pulse width wrong");
  property p_pulse_idle;
    pls && st_q[1] && calm && !busy_o && !$past(busy_o)
      |-> !sck && !fss && !serial_out_pin_oe_o;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle)
    else $error("pulse format idle pins wrong");
  property p_masked;
    st_q == 2'h3 && calm
      |-> masked_interrupt_status_o == (raw & cfg_i.interrupt_mask_reg);
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked status wrong");
  property p_irq;
    st_q == 2'h3 |-> irq_o == (|masked_interrupt_status_o);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line wrong");
  property p_tx_dma;
    cfg_i.dma_tx_en && st_q[1] && calm
      |-> dma_req_o.tx_single == $past(tx_space_o);
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("transmit single request wrong");
  property p_rx_burst;
    cfg_i.dma_rx_en && st_q[1] && calm
      |-> dma_req_o.rx_burst == raw[IRQ_RXSVC];
  endproperty
  a_rx_burst: assert property (p_rx_burst)
    else $error("receive burst request wrong");
  property p_rx_to;
    $rose(raw[IRQ_RXTO]) |-> rx_valid_o;
  endproperty
  a_rx_to: assert property (p_rx_to)
    else $error("timeout without receive data");
endmodule : ssp_chk

// *** test/ssp_slave_model.sv ***
// Far-end slave with clock polarity and phase zero, one word a frame
module ssp_slave_model (
  input  wire logic        sclk_i,
  input  wire logic        fss_n_i,
  input  wire logic        mosi_i,
  input  wire logic [15:0] reply_i,
  input  wire logic [3:0]  size_m1_i,
  output logic             miso_o,
  output logic [15:0]      got_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int idx = 0;
  initial begin
    miso_o = 1'b0;
    got_o = 16'h0000;
  end
  // Selection presents the reply MSB first
  always @(negedge fss_n_i) begin
    idx = int'(size_m1_i);
    got_o = 16'h0000;
    miso_o = reply_i[idx];
  end
  // Master bits are taken on the rising edge
  always @(posedge sclk_i) if (!fss_n_i) got_o = {got_o[14:0], mosi_i};
  // Next reply bit follows each falling edge
  always @(negedge sclk_i) begin
    if (!fss_n_i && idx > 0) begin
      idx--;
      miso_o = reply_i[idx];
    end
  end
  // Released line shows the inverse of its last bit
  always @(posedge fss_n_i) miso_o = ~miso_o;
endmodule : ssp_slave_model

// *** test/ssp_core_test.sv ***
// Self-checking bench for the serial port core and a far-end slave
module ssp_core_test
  import ssp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk_sys_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic             tx_wr = 1'b0;
  logic             rx_rd = 1'b0;
  logic [15:0]      tx_wdata = 16'h0000;
  logic [15:0]      reply = 16'h0000;
  logic [IRQ_N-1:0] clr = 5'h00;
  ssp_cfg_t         cfg;
  ssp_dma_t         dma;
  logic [IRQ_N-1:0] raw, msk;
  logic [15:0]      rdata, got;
  logic             tx_space, rx_valid, irq, busy, sclk, fss, sout, soe, miso;
  int               err_count = 0;
  int               n_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ssp_core ssp_core_i (.clk_sys_i, .rstn_i, .cfg_i(cfg), .tx_wr_i(tx_wr),
    .tx_wdata_i(tx_wdata), .tx_space_o(tx_space), .rx_valid_o(rx_valid),
    .rx_rdata_o(rdata), .rx_rd_i(rx_rd), .int_clear_i(clr),
    .raw_interrupt_status_o(raw), .masked_interrupt_status_o(msk),
    .irq_o(irq), .dma_req_o(dma), .busy_o(busy), .serial_clock_pin_o(sclk),
    .frame_select_pin_o(fss), .serial_out_pin_o(sout),
    .serial_out_pin_oe_o(soe), .serial_in_pin_i(miso));
  ssp_slave_model ssp_slave_model_i (.sclk_i(sclk), .fss_n_i(fss),
    .mosi_i(sout), .reply_i(reply), .size_m1_i(cfg.size_m1),
    .miso_o(miso), .got_o(got));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic wr(input int n, input logic [15:0] w);
    tx_wr = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_wdata = w + 16'(i);
      tick(1);
    end
    tx_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [15:0] exp, input logic any);
    for (int i = 0; i < 500 && rx_valid !== 1'b1; i++) tick(1);
    chk({15'h0, rx_valid}, 16'h0001);
    if (!any) chk(rdata, exp);
    else chk({15'h0, rx_valid}, 16'h0001);
    rx_rd = 1'b1;
    tick(1);
    rx_rd = 1'b0;
    tick(1);
  endtask : rd
  task automatic idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
    chk({15'h0, busy}, 16'h0000);
  endtask : idle
  task automatic t_reset;
    chk({14'h0, fss, sclk}, 16'h0002);
    chk({15'h0, tx_space}, 16'h0001);
    chk({12'h0, dma}, 16'h0003);
    chk({11'h0, raw}, 16'h0011);
    $display("reset test done");
  endtask : t_reset
  task automatic t_spi;
    reply = 16'h003C;
    wr(2, 16'h00A5);
    idle;
    chk(got, 16'h00A6);
    chk({15'h0, sclk}, 16'h0000);
    rd(16'h003C, 1'b0);
    rd(16'h003C, 1'b0);
    $display("spi test done");
  endtask : t_spi
  task automatic t_modes;
    cfg.loopback = 1'b1;
    cfg.size_m1 = SIZE_MIN_M1;
    for (int m = 0; m < 5; m++) begin
      cfg.format = (m == 4) ? SSP_FMT_CMD : SSP_FMT_SPI;
      {cfg.clock_polarity_bit, cfg.clock_phase_bit} = 2'(m);
      tick(4);
      // Phase one modes send two words back to back
      wr(1 + m % 2, 16'hFFFB);
      idle;
      chk({15'h0, sclk}, 16'(m[1]));
      rd(16'h000B, m == 4);
      if (m % 2 == 1) rd(16'h000C, 1'b0);
    end
    $display("mode test done");
  endtask : t_modes
  task automatic t_fifo;
    cfg.enable = 1'b0;
    wr(9, 16'h1230);
    chk({15'h0, tx_space}, 16'h0000);
    chk({12'h0, dma}, 16'h0000);
    cfg.format = SSP_FMT_PULSE;
    cfg.size_m1 = 4'hF;
    cfg.clock_prescale_divisor = PRESC_MIN;
    cfg.serial_clock_rate = 8'h00;
    cfg.enable = 1'b1;
    tick(1);
    idle;
    chk({12'h0, dma}, 16'h000F);
    tick(80);
    chk({11'h0, raw}, 16'h0017);
    cfg.interrupt_mask_reg = 5'h08;
    tick(3);
    chk({15'h0, irq}, 16'h0000);
    cfg.interrupt_mask_reg = 5'h02;
    tick(3);
    chk({10'h0, irq, msk}, 16'h0022);
    // Loopback plays the far end, answering in step from the fourth edge
    for (int i = 0; i < 8; i++) rd(16'h1230 + 16'(i), 1'b0);
    clr = 5'h04;
    tick(1);
    clr = 5'h00;
    tick(2);
    chk({11'h0, raw}, 16'h0011);
    $display("fifo test done");
  endtask : t_fifo
  // Main sequence: reset for four cycles, then each test in turn
  initial begin
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.size_m1 = 4'h7;
    cfg.clock_prescale_divisor = 8'h04;
    cfg.serial_clock_rate = 8'h01;
    cfg.dma_rx_en = 1'b1;
    cfg.dma_tx_en = 1'b1;
    tick(4);
    rstn_i = 1'b1;
    tick(2);
    t_reset;
    t_spi;
    t_modes;
    t_fifo;
    end_sim;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    err_count++;
    end_sim;
  end
endmodule : ssp_core_test
bind ssp_core ssp_chk ssp_chk_i (.clk_sys_i, .rstn_i, .cfg_i, .tx_space_o,
  .rx_valid_o, .raw_interrupt_status_o, .masked_interrupt_status_o, .irq_o,
  .dma_req_o, .busy_o, .serial_clock_pin_o, .frame_select_pin_o,
  .serial_out_pin_oe_o);
